// ==== design/dds_serial_load.sv ====
// Serial word loader and output update control for a dual converter.
`timescale 1ns/1ps
module dds_serial_load
  import dds_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  input  wire logic                   shiftClk,
  input  wire logic                   frameSync_b,
  input  wire logic                   serialData,
  output logic [SAMPLE_BITS-1:0]      outCodeA,
  output logic [SAMPLE_BITS-1:0]      outCodeB,
  output logic                        powerDown,
  output dds_term_e                   termSel,
  output logic                        updatePulse
);

  // ****************************************************************
  // Link domain: shift register on falling shift-clock edges
  // ****************************************************************
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] shift_d;
  logic [CNT_BITS-1:0]  bitCnt_q;
  logic [CNT_BITS-1:0]  bitCnt_d;
  dds_word_s            word_q;
  dds_word_s            word_d;
  logic                 wordTgl_q;
  logic                 wordTgl_d;
  logic [WORD_BITS-1:0] fullWord;
  logic                 cntClr;

  // The strobe clears the counter asynchronously so a frame ended early
  // leaves nothing behind, even with the shift clock stopped.
  always_comb begin
    shift_d   = shift_q;
    bitCnt_d  = bitCnt_q;
    word_d    = word_q;
    wordTgl_d = wordTgl_q;
    fullWord  = {shift_q[WORD_BITS-2:0], serialData};
    if (bitCnt_q != CNT_LAST + 5'h01) begin
      shift_d  = fullWord;
      bitCnt_d = bitCnt_q + 5'h01;
      if (bitCnt_q == CNT_LAST) begin
        word_d    = dds_word_s'(fullWord);
        wordTgl_d = ~wordTgl_q;
      end
    end
  end

  // The system reset clears the count as well, so a reset in mid-frame
  // cannot leave a stale count behind for the next frame.
  assign cntClr = frameSync_b | ~rst_b;

  always_ff @(negedge shiftClk or posedge cntClr) begin
    if (cntClr) begin
      bitCnt_q <= CNT_RESET;
    end else begin
      bitCnt_q <= bitCnt_d;
    end
  end

  always_ff @(negedge shiftClk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q   <= '0;
      word_q    <= '0;
      wordTgl_q <= 1'b0;
    end else begin
      shift_q   <= shift_d;
      word_q    <= word_d;
      wordTgl_q <= wordTgl_d;
    end
  end

  // ****************************************************************
  // System domain: catch toggle, apply word
  // ****************************************************************
  logic                   tglSync;
  logic                   tglSeen_q;
  logic                   tglSeen_d;
  logic [SAMPLE_BITS-1:0] outA_q;
  logic [SAMPLE_BITS-1:0] outA_d;
  logic [SAMPLE_BITS-1:0] outB_q;
  logic [SAMPLE_BITS-1:0] outB_d;
  logic [SAMPLE_BITS-1:0] holdA_q;
  logic [SAMPLE_BITS-1:0] holdA_d;
  logic [SAMPLE_BITS-1:0] holdB_q;
  logic [SAMPLE_BITS-1:0] holdB_d;
  logic                   pd_q;
  logic                   pd_d;
  dds_term_e              term_q;
  dds_term_e              term_d;
  logic                   upd_q;
  logic                   upd_d;
  logic                   newWord;

  dds_sync2 u_tglSync (
    .clock (clock),
    .rst_b (rst_b),
    .din   (wordTgl_q),
    .dout  (tglSync)
  );

  // The word is stable in the link domain until the next frame completes,
  // which is far longer than the synchroniser delay.
  always_comb begin
    newWord   = tglSync ^ tglSeen_q;
    tglSeen_d = tglSync;
    outA_d    = outA_q;
    outB_d    = outB_q;
    holdA_d   = holdA_q;
    holdB_d   = holdB_q;
    pd_d      = pd_q;
    term_d    = term_q;
    upd_d     = 1'b0;
    if (newWord) begin
      upd_d = 1'b1;
      unique case (word_q.mode)
        DDS_MODE_WRITE_ONE: begin
          if (word_q.channel) begin
            holdB_d = word_q.sample;
          end else begin
            holdA_d = word_q.sample;
          end
        end
        DDS_MODE_UPDATE_ONE: begin
          pd_d = 1'b0;
          if (word_q.channel) begin
            outB_d = word_q.sample;
            holdB_d = word_q.sample;
          end else begin
            outA_d = word_q.sample;
            holdA_d = word_q.sample;
          end
        end
        DDS_MODE_WRITE_BOTH: begin
          pd_d    = 1'b0;
          outA_d  = word_q.sample;
          outB_d  = word_q.sample;
          holdA_d = word_q.sample;
          holdB_d = word_q.sample;
        end
        DDS_MODE_POWER_DOWN: begin
          pd_d   = 1'b1;
          term_d = dds_term_e'({word_q.channel, word_q.pdBit});
          if (term_d == DDS_TERM_NONE) begin
            pd_d = 1'b0;
            outA_d = holdA_q;
            outB_d = holdB_q;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tglSeen_q <= 1'b0;
      outA_q    <= SAMPLE_RESET;
      outB_q    <= SAMPLE_RESET;
      holdA_q   <= SAMPLE_RESET;
      holdB_q   <= SAMPLE_RESET;
      pd_q      <= 1'b0;
      term_q    <= DDS_TERM_NONE;
      upd_q     <= 1'b0;
    end else begin
      tglSeen_q <= tglSeen_d;
      outA_q    <= outA_d;
      outB_q    <= outB_d;
      holdA_q   <= holdA_d;
      holdB_q   <= holdB_d;
      pd_q      <= pd_d;
      term_q    <= term_d;
      upd_q     <= upd_d;
    end
  end

  assign outCodeA    = outA_q;
  assign outCodeB    = outB_q;
  assign powerDown   = pd_q;
  assign termSel     = term_q;
  assign updatePulse = upd_q;

endmodule // dds_serial_load

// ==== common/dds_pkg.sv ====
// Package with constants and types for the dual converter serial loader.
package dds_pkg;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int WORD_BITS   = 16;
  localparam int SAMPLE_BITS = 12;
  localparam int CNT_BITS    = 5;
  localparam int CHAN_POS    = 15;
  localparam int MODE_MSB    = 14;
  localparam int MODE_LSB    = 13;
  localparam int PD_POS      = 12;
  localparam logic [SAMPLE_BITS-1:0] SAMPLE_RESET = 12'h000;
  localparam logic [CNT_BITS-1:0]    CNT_RESET    = 5'h00;
  localparam logic [CNT_BITS-1:0]    CNT_LAST     = 5'h0f;

  // ****************************************************************
  // Modes and termination options
  // ****************************************************************
  typedef enum logic [1:0] {
    DDS_MODE_WRITE_ONE  = 2'h0,
    DDS_MODE_UPDATE_ONE = 2'h1,
    DDS_MODE_WRITE_BOTH = 2'h2,
    DDS_MODE_POWER_DOWN = 2'h3
  } dds_mode_e;

  typedef enum logic [1:0] {
    DDS_TERM_NONE  = 2'h0,
    DDS_TERM_LOW_R = 2'h1,
    DDS_TERM_HIGH_R = 2'h2,
    DDS_TERM_HIGHZ = 2'h3
  } dds_term_e;

  // A received frame as it crosses into the system domain.
  typedef struct packed {
    logic                   channel;
    dds_mode_e              mode;
    logic                   pdBit;
    logic [SAMPLE_BITS-1:0] sample;
  } dds_word_s;

endpackage

// ==== design/dds_sync2.sv ====
// Two-flop synchroniser for a single level.
`timescale 1ns/1ps
module dds_sync2
  import dds_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      dout
);

  logic stage1_q;
  logic stage1_d;
  logic stage2_q;
  logic stage2_d;

  always_comb begin
    stage1_d = din;
    stage2_d = stage1_q;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign dout = stage2_q;

endmodule // dds_sync2

// ==== bench/dds_host_model.sv ====
// Serial host model that sends control words to the loader.
`timescale 1ns/1ps
module dds_host_model (
  output logic shiftClk,
  output logic frameSync_b,
  output logic serialData
);
  initial begin
    shiftClk = 1'b1;
    frameSync_b = 1'b1;
    serialData = 1'b0;
  end
  // Sends the first n bits of w; the clock stands high between frames.
  task automatic send(input logic [15:0] w, input int n);
    frameSync_b = 1'b0;
    #16;
    for (int i = 0; i < n; i++) begin
      serialData = w[15-i];
      #16 shiftClk = 1'b0;
      #16 shiftClk = 1'b1;
    end
    #300 frameSync_b = 1'b1;
    serialData = ~serialData;
    #200;
  endtask
endmodule // dds_host_model

// ==== bench/dds_serial_load_checker.sv ====
// Checker of the loader's update behaviour.
`timescale 1ns/1ps
module dds_serial_load_checker import dds_pkg::*; (
  input wire logic                   clock,
  input wire logic                   rst_b,
  input wire logic                   shiftClk,
  input wire logic                   frameSync_b,
  input wire logic                   serialData,
  input wire logic [SAMPLE_BITS-1:0] outCodeA,
  input wire logic [SAMPLE_BITS-1:0] outCodeB,
  input wire logic                   powerDown,
  input wire dds_term_e              termSel,
  input wire logic                   updatePulse
);
  logic [15:0] w;
  logic [4:0]  cnt;
  // Shadow of the received word and its edge count.
  always_ff @(negedge shiftClk or negedge rst_b or posedge frameSync_b) begin
    if (!rst_b) begin
      cnt <= 5'h00;
      w <= 16'h0000;
    end else if (frameSync_b) begin
      cnt <= 5'h00;
    end else if (cnt < 5'h10) begin
      cnt <= cnt + 5'h01;
      w <= {w[14:0], serialData};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  chk_pulse_single: assert property (updatePulse |=> !updatePulse)
    else $error("pulse too long");
  chk_out_hold: assert property (!updatePulse |->
    $stable({outCodeA, outCodeB, powerDown, termSel})) else $error("drift");
  chk_full_word: assert property (updatePulse |-> cnt == 5'h10)
    else $error("short frame applied");
  chk_pulse_late: assert property ($rose(cnt == 5'h10) |->
    ##[1:6] updatePulse) else $error("no update");
  chk_both_update: assert property (updatePulse &&
    w[14:13] == 2'h2 |-> outCodeA == w[11:0] && outCodeB == w[11:0])
    else $error("both");
  chk_one_update: assert property (updatePulse &&
    w[14:13] == 2'h1 |-> (w[15] ? outCodeB : outCodeA) == w[11:0] &&
    (w[15] ? $stable(outCodeA) : $stable(outCodeB))) else $error("one");
  chk_load_only: assert property (updatePulse && w[14:13] == 2'h0 |->
    $stable({outCodeA, outCodeB})) else $error("load changed output");
  chk_pd_term: assert property (updatePulse && w[14:13] == 2'h3 |->
    termSel == {w[15], w[12]} && powerDown == (w[15] | w[12]))
    else $error("power-down");
  cov_both: cover property (updatePulse && w[14:13] == 2'h2);
  cov_sleep: cover property (updatePulse && powerDown);
  cov_abort: cover property (cnt == 5'h0f ##1 cnt == 5'h00);
endmodule // dds_serial_load_checker

// ==== bench/tb_dds_serial_load.sv ====
// Testbench of the dual converter serial loader.
`timescale 1ns/1ps
module tb_dds_serial_load import dds_pkg::*;;
  logic clock, rst_b, shiftClk, frameSync_b, serialData;
  logic powerDown, updatePulse;
  logic [SAMPLE_BITS-1:0] outCodeA, outCodeB;
  dds_term_e termSel;
  int n_errors = 0, checks = 0, pulses = 0, cyc = 0;
  dds_host_model u_dds_host_model (.shiftClk(shiftClk),
    .frameSync_b(frameSync_b), .serialData(serialData));
  dds_serial_load u_dds_serial_load (.clock(clock), .rst_b(rst_b),
    .shiftClk(shiftClk), .frameSync_b(frameSync_b), .serialData(serialData),
    .outCodeA(outCodeA), .outCodeB(outCodeB), .powerDown(powerDown),
    .termSel(termSel), .updatePulse(updatePulse));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(negedge clock) begin
    pulses += int'(updatePulse === 1'b1);
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic outs(input logic [11:0] a, b, input logic p,
                      input dds_term_e t);
    check(outCodeA, a);
    check(outCodeB, b);
    check(12'(powerDown), 12'(p));
    check(12'(termSel), 12'(t));
  endtask
  task automatic frame(input logic [15:0] w, input int n, input logic [11:0] a,
                       b, input logic p, input dds_term_e t);
    int p0;
    p0 = pulses;
    u_dds_host_model.send(w, n);
    outs(a, b, p, t);
    check(12'(pulses - p0), (n == 16) ? 12'h001 : 12'h000);
  endtask
  task automatic sc_both_one;
    frame(16'h4a5c, 16, 12'ha5c, 12'ha5c, 1'b0, DDS_TERM_NONE);
    frame(16'ha3f1, 16, 12'ha5c, 12'h3f1, 1'b0, DDS_TERM_NONE);
  endtask
  task automatic sc_abort;
    int p;
    p = pulses;
    frame(16'h4fff, 15, 12'ha5c, 12'h3f1, 1'b0, DDS_TERM_NONE);
    check(12'(pulses - p), 12'h000);
  endtask
  task automatic sc_sleep_wake;
    for (int i = 1; i < 4; i++) begin
      frame({i[1], 2'h3, i[0], 12'h000}, 16, 12'ha5c, 12'h3f1, 1'b1,
            dds_term_e'(i));
    end
    frame(16'h0777, 16, 12'ha5c, 12'h3f1, 1'b1, DDS_TERM_HIGHZ);
    frame(16'h6000, 16, 12'h777, 12'h3f1, 1'b0, DDS_TERM_NONE);
  endtask
  task automatic sc_reset_hold;
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    outs(12'h000, 12'h000, 1'b0, DDS_TERM_NONE);
    rst_b <= 1'b1;
    @(posedge clock);
    frame(16'hc5a5, 15, 12'h000, 12'h000, 1'b0, DDS_TERM_NONE);
    frame(16'hc5a5, 16, 12'h5a5, 12'h5a5, 1'b0, DDS_TERM_NONE);
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    outs(12'h000, 12'h000, 0, DDS_TERM_NONE);
    sc_both_one();
    sc_abort();
    sc_sleep_wake();
    sc_reset_hold();
    tally_and_finish();
  end
endmodule // tb_dds_serial_load
bind dds_serial_load dds_serial_load_checker u_chk (.clock(clock),
  .rst_b(rst_b), .shiftClk(shiftClk), .frameSync_b(frameSync_b),
  .serialData(serialData), .outCodeA(outCodeA), .outCodeB(outCodeB),
  .powerDown(powerDown), .termSel(termSel), .updatePulse(updatePulse));
